// ### inc/adcrc_pkg.sv
package adcrc_pkg;

    // Register indices; the bus byte address of each is four times its index.
    localparam int          ADDR_W        = 18;
    localparam logic [15:0] IDX_CTRL      = 16'h7f20;
    localparam logic [15:0] IDX_MODE      = 16'h7f21;
    localparam logic [15:0] IDX_LOW       = 16'h7f22;
    localparam logic [15:0] IDX_HIGH      = 16'h7f23;

    // Reset values.
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  MODE_RESET    = 8'h00;
    localparam logic [7:0]  LOW_RESET     = 8'h00;
    localparam logic [7:0]  HIGH_RESET    = 8'h00;

    // Control register fields.
    localparam int          CTRL_CHAN_LSB  = 4;
    localparam int          CTRL_CMP_BIT   = 3;
    localparam int          CTRL_START_BIT = 2;
    localparam int          CTRL_DONE_BIT  = 1;
    localparam int          CTRL_IE_BIT    = 0;

    // Mode register fields.
    localparam int          MODE_RESOLUTION_SELECT_BIT = 6;
    localparam int          MODE_ADJ_BIT   = 2;
    localparam int          MODE_DIV_LSB   = 0;

    // Low result register fields.
    localparam int          LOW_NIB_LSB    = 4;
    localparam int          LOW_CMP_BIT    = 7;
    localparam int          LOW_DIVU_BIT   = 0;

    // Front end and timing.
    localparam int          CHANNELS       = 16;
    localparam int          RESULT_W       = 12;
    localparam int          CNT_W          = 16;
    localparam int          CONV12_STEPS   = 52;
    localparam int          CONV8_STEPS    = 32;
    localparam int          CMP_STEPS      = 28;
    localparam int          TAIL_CYCLES    = 2;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_STEP = 3'b010,
        SEQ_TAIL = 3'b100
    } adcrc_seq_state_type;

endpackage

// ### inc/adcrc_seq_if.sv
`timescale 1ns/1ps
interface adcrc_seq_if;
    logic                          start;
    logic                          abort;
    logic [2:0]                    div_sel;
    logic [adcrc_pkg::CNT_W-1:0]   steps;
    logic [2:0]                    tail;
    logic                          busy;
    logic                          done;

    modport ctrl (output start, abort, div_sel, steps, tail, input busy, done);
    modport seq  (input start, abort, div_sel, steps, tail, output busy, done);
endinterface

// ### src/adcrc_seq.sv
`timescale 1ns/1ps
module adcrc_seq (
    // Clock and reset
    input  wire logic     clk_sys,
    input  wire logic     resetn,
    // Sequencer control
    adcrc_seq_if.seq      sq
);
    import adcrc_pkg::*;

    adcrc_seq_state_type  state_q;
    logic [CNT_W-1:0]     step_q;
    logic [2:0]           tail_q;
    logic [7:0]           div_cnt_q;
    logic [7:0]           ratio_m1;
    logic                 tick;

    // The conversion clock is a one-cycle enable every ratio cycles.
    assign ratio_m1 = (8'h01 << sq.div_sel) - 8'h01;
    assign tick     = (div_cnt_q == ratio_m1);
    assign sq.busy  = (state_q != SEQ_IDLE);
    assign sq.done  = (state_q == SEQ_TAIL) && (tail_q == 3'h1);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q   <= SEQ_IDLE;
            step_q    <= '0;
            tail_q    <= 3'h0;
            div_cnt_q <= 8'h00;
        end else if (sq.abort) begin
            state_q   <= SEQ_IDLE; // see [R14]
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    if (sq.start) begin
                        state_q   <= SEQ_STEP; // see [R20]
                        step_q    <= sq.steps;
                        tail_q    <= sq.tail;
                        div_cnt_q <= 8'h00;
                    end
                end
                SEQ_STEP: begin
                    if (tick) begin
                        div_cnt_q <= 8'h00; // see [R22]
                        if (step_q == CNT_W'(1)) begin
                            state_q <= SEQ_TAIL; // see [R23]
                        end else begin
                            step_q <= step_q - CNT_W'(1);
                        end
                    end else begin
                        div_cnt_q <= div_cnt_q + 8'h01;
                    end
                end
                SEQ_TAIL: begin
                    if (tail_q == 3'h1) begin
                        state_q <= SEQ_IDLE;
                    end else begin
                        tail_q <= tail_q - 3'h1;
                    end
                end
                default: begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    a_abort_idle: assert property (@(posedge clk_sys) disable iff (!resetn) // see [R14]
        sq.abort |=> !sq.busy)
        else $error("abort did not return the sequencer to idle");

    a_done_single: assert property (@(posedge clk_sys) disable iff (!resetn) // see [R17]
        sq.done |=> !sq.done && !sq.busy)
        else $error("completion was not a single cycle");

endmodule

// ### src/adcrc_top.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Function
// [R1] 12-bit mode: low nibble into low bits 7:4.
// [R2] Compare mode: outcome into low bit 7.
// [R3] Result registers are plain storage when idle.
// [R4] Software writes zero to low bits 3:1.
// [R5] Low bit 0 is divider select upper bit.
// [R6] High register gets upper or full result.
// [R7] Software reads results only after completion.
// [R8] Divider code 101 selects divide by 32.
// [R9] Channel code 0001 routes input one.
// [R10] Compare needs compare, offset set, resolution clear; the code selects a comparison on the compare bit alone.
// [R11] Comparison takes 28 times ratio plus two.
// [R12] Software loads reference into high before compare.
// [R13] Outcome 1 when reference below input level.
// [R14] Writing start zero while running aborts.
// [R15] Software stops before any low-power mode.
// [R16] Reset clears start and stops converter.
// [R17] Completion sets done, clears start together.
// [R18] Done with enable raises interrupt request.
// [R19] Software polls done, then clears it.
// [R20] Writing start one begins the operation.
// [R21] Software clears resolution bit for 12-bit.
// [R22] Divider codes map to ratios 1 to 128.
// [R23] Conversion takes 52 or 32 times ratio plus two.
// [R24] 8-bit mode leaves low register unchanged.
// [R25] First 12-bit conversion after reset/switch takes double.
// [R26] Channel n routes input level n.
// [R27] Write zero clears done; completion wins.
module adcrc_top #(
    parameter int STEPS12  = adcrc_pkg::CONV12_STEPS,
    parameter int STEPS8   = adcrc_pkg::CONV8_STEPS,
    parameter int STEPSCMP = adcrc_pkg::CMP_STEPS
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          resetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [adcrc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Analog front end
    input  wire logic [adcrc_pkg::CHANNELS*adcrc_pkg::RESULT_W-1:0] analog_input_level,
    output logic      [3:0]                    channel_select,
    output logic                               conv_active,
    output logic                               offset_comp_enable,
    // Interrupt request
    output logic                               done_irq
);
    import adcrc_pkg::*;

    adcrc_seq_if          sq ();

    logic [3:0]           chan_q;
    logic                 cmp_q;
    logic                 start_q;
    logic                 done_q;
    logic                 ie_q;
    logic                 resolution_select_q;
    logic                 adj_q;
    logic [1:0]           div_lo_q;
    logic [3:0]           nib_q;
    logic                 div_hi_q;
    logic [7:0]           high_q;
    logic                 first12_q;
    logic                 run_cmp_q;
    logic                 run_resolution_select_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic [31:0]          prdata_q;
    logic                 irq_q;
    logic [15:0]          idx;
    logic                 hit;
    logic                 setup;
    logic                 wr_en;
    logic                 ctrl_wr;
    logic                 mode_wr;
    logic                 low_wr;
    logic                 high_wr;
    logic                 launch;
    logic                 dbl;
    logic [7:0]           rd_byte;
    logic [RESULT_W-1:0]  lvl_sel;
    logic [CNT_W-1:0]     steps_d;
    logic [2:0]           tail_d;
    logic [31:0]          len_q;
    logic [31:0]          exp_q;

    // Bus decode; a write takes effect at the edge that completes the access phase.
    assign idx     = paddr[ADDR_W-1:2];
    assign hit     = (paddr[1:0] == 2'b00) &&
                     (idx == IDX_CTRL || idx == IDX_MODE || idx == IDX_LOW || idx == IDX_HIGH);
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready_q && pwrite && hit;
    assign ctrl_wr = wr_en && (idx == IDX_CTRL);
    assign mode_wr = wr_en && (idx == IDX_MODE);
    assign low_wr  = wr_en && (idx == IDX_LOW);
    assign high_wr = wr_en && (idx == IDX_HIGH);

    // The front end model presents a digital level per channel.
    assign lvl_sel = analog_input_level[chan_q*RESULT_W +: RESULT_W]; // see [R9] [R26]

    // A start write to a running converter neither restarts nor aborts it.
    assign launch     = ctrl_wr && pwdata[CTRL_START_BIT] && !sq.busy; // see [R20]
    assign dbl        = !pwdata[CTRL_CMP_BIT] && !resolution_select_q && first12_q;
    assign sq.start   = launch;
    assign sq.abort   = ctrl_wr && !pwdata[CTRL_START_BIT] && sq.busy && !sq.done; // see [R14]
    assign sq.div_sel = {div_hi_q, div_lo_q}; // see [R5] [R8] [R22]
    assign sq.steps   = steps_d;
    assign sq.tail    = tail_d;

    // Step count is in conversion clock ticks; the tail is in system cycles.
    always_comb begin
        if (pwdata[CTRL_CMP_BIT]) begin
            steps_d = CNT_W'(STEPSCMP); // see [R11]
        end else if (resolution_select_q) begin
            steps_d = CNT_W'(STEPS8); // see [R23]
        end else if (first12_q) begin
            steps_d = CNT_W'(STEPS12 * 2); // see [R25]
        end else begin
            steps_d = CNT_W'(STEPS12); // see [R23]
        end
        tail_d = dbl ? 3'(TAIL_CYCLES * 2) : 3'(TAIL_CYCLES);
    end

    always_comb begin
        if (idx == IDX_CTRL) begin
            rd_byte = {chan_q, cmp_q, start_q, done_q, ie_q};
        end else if (idx == IDX_MODE) begin
            rd_byte = {1'b0, resolution_select_q, 3'b000, adj_q, div_lo_q};
        end else if (idx == IDX_LOW) begin
            rd_byte = {nib_q, 3'b000, div_hi_q};
        end else if (idx == IDX_HIGH) begin
            rd_byte = high_q;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Answering in the setup cycle gives zero wait states on every access.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit;
            if (setup) begin
                prdata_q <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_q <= CTRL_RESET[CTRL_CHAN_LSB +: 4];
            cmp_q  <= CTRL_RESET[CTRL_CMP_BIT];
            ie_q   <= CTRL_RESET[CTRL_IE_BIT];
        end else if (ctrl_wr) begin
            chan_q <= pwdata[CTRL_CHAN_LSB +: 4];
            cmp_q  <= pwdata[CTRL_CMP_BIT];
            ie_q   <= pwdata[CTRL_IE_BIT];
        end
    end

    // Reset stops a running conversion by clearing start and the sequencer.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            start_q <= CTRL_RESET[CTRL_START_BIT]; // see [R16]
        end else if (sq.done) begin
            start_q <= 1'b0; // see [R17]
        end else if (ctrl_wr) begin
            start_q <= pwdata[CTRL_START_BIT]; // see [R14] [R20]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            done_q <= CTRL_RESET[CTRL_DONE_BIT];
        end else if (sq.done) begin
            done_q <= 1'b1; // see [R17] [R27]
        end else if (ctrl_wr && !pwdata[CTRL_DONE_BIT]) begin
            done_q <= 1'b0; // see [R27]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            resolution_select_q  <= MODE_RESET[MODE_RESOLUTION_SELECT_BIT];
            adj_q    <= MODE_RESET[MODE_ADJ_BIT];
            div_lo_q <= MODE_RESET[MODE_DIV_LSB +: 2];
        end else if (mode_wr) begin
            resolution_select_q  <= pwdata[MODE_RESOLUTION_SELECT_BIT];
            adj_q    <= pwdata[MODE_ADJ_BIT];
            div_lo_q <= pwdata[MODE_DIV_LSB +: 2];
        end
    end

    // Mode is frozen at launch so a stray write cannot change where results land.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run_cmp_q   <= 1'b0;
            run_resolution_select_q <= 1'b0;
        end else if (launch) begin
            run_cmp_q   <= pwdata[CTRL_CMP_BIT];
            run_resolution_select_q <= resolution_select_q;
        end
    end

    // A double-length conversion is owed after reset and after any 8-bit period.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            first12_q <= 1'b1; // see [R25]
        end else if (resolution_select_q) begin
            first12_q <= 1'b1; // see [R25]
        end else if (sq.done && !run_cmp_q && !run_resolution_select_q) begin
            first12_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_hi_q <= LOW_RESET[LOW_DIVU_BIT];
        end else if (low_wr) begin
            div_hi_q <= pwdata[LOW_DIVU_BIT]; // see [R5]
        end
    end

    // Completion wins over a software write landing in the same cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            nib_q <= LOW_RESET[LOW_NIB_LSB +: 4];
        end else if (sq.done && run_cmp_q) begin
            nib_q[LOW_CMP_BIT-LOW_NIB_LSB] <= (high_q < lvl_sel[RESULT_W-1 -: 8]); // see [R2] [R13]
        end else if (sq.done && !run_resolution_select_q) begin
            nib_q <= lvl_sel[3:0]; // see [R1]
        end else if (low_wr && !(sq.done && run_resolution_select_q)) begin
            nib_q <= pwdata[LOW_NIB_LSB +: 4]; // see [R3] [R24]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            high_q <= HIGH_RESET;
        end else if (sq.done && !run_cmp_q) begin
            high_q <= lvl_sel[RESULT_W-1 -: 8]; // see [R6]
        end else if (high_wr) begin
            high_q <= pwdata[7:0]; // see [R3]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_q && ie_q; // see [R18]
        end
    end

    adcrc_seq u_seq (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .sq      (sq)
    );

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign channel_select     = chan_q;
    assign conv_active        = start_q;
    assign offset_comp_enable = adj_q;
    assign done_irq           = irq_q;

    // Helper counters that let the length of each operation be checked.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            len_q <= 32'h0000_0000;
            exp_q <= 32'h0000_0000;
        end else if (launch) begin
            len_q <= 32'h0000_0000;
            exp_q <= 32'(steps_d) * (32'h0000_0001 << sq.div_sel) + 32'(tail_d);
        end else if (sq.busy) begin
            len_q <= len_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!resetn);

    a_done_clears_start: assert property ( // see [R17]
        sq.done |=> done_q && !start_q)
        else $error("completion did not set done and clear start");

    a_done_set_wins: assert property ( // see [R27]
        sq.done && ctrl_wr && !pwdata[CTRL_DONE_BIT] |=> done_q)
        else $error("clearing write beat a completion");

    a_abort_stops: assert property ( // see [R14]
        sq.abort |=> !start_q && !sq.busy && !$rose(done_q))
        else $error("abort left the converter running");

    a_launch_runs: assert property ( // see [R20]
        launch |=> start_q && sq.busy)
        else $error("start write did not begin an operation");

    a_op_length: assert property ( // see [R11] [R23] [R25]
        sq.done |-> len_q + 32'h0000_0001 == exp_q)
        else $error("operation length differs from the selected time");

    a_irq_follows: assert property ( // see [R18]
        done_q && ie_q |=> done_irq)
        else $error("interrupt request missing after completion");

    a_irq_quiet: assert property ( // see [R18]
        !(done_q && ie_q) |=> !done_irq)
        else $error("interrupt request without enabled done flag");

    a_high_result: assert property ( // see [R6]
        sq.done && !run_cmp_q |=> high_q == $past(lvl_sel[RESULT_W-1 -: 8]))
        else $error("high result register missed the upper result bits");

    a_low_nibble: assert property ( // see [R1]
        sq.done && !run_cmp_q && !run_resolution_select_q |=> nib_q == $past(lvl_sel[3:0]))
        else $error("low nibble missed the lower result bits");

    a_low_kept: assert property ( // see [R24]
        sq.done && run_resolution_select_q && !run_cmp_q |=> $stable(nib_q))
        else $error("8-bit conversion disturbed the low result register");

    a_cmp_outcome: assert property ( // see [R2] [R13]
        sq.done && run_cmp_q |=>
            nib_q[3] == ($past(high_q) < $past(lvl_sel[RESULT_W-1 -: 8])))
        else $error("comparison outcome bit is wrong");

    a_high_storage: assert property ( // see [R3]
        high_wr && !sq.busy |=> high_q == $past(pwdata[7:0]))
        else $error("idle write to high result register not stored");

    a_chan_route: assert property ( // see [R9] [R26]
        ctrl_wr |=> channel_select == $past(pwdata[CTRL_CHAN_LSB +: 4]))
        else $error("channel select not taken from control write");

    a_zero_wait: assert property (
        setup |=> pready ##1 !pready)
        else $error("access phase did not complete in one cycle");

endmodule

// ### verification/adcrc_fe_model.sv
`timescale 1ns/1ps
module adcrc_fe_model (
    // Routing from the block
    input  wire logic [3:0]                                     channel_select,
    // Level setting from the bench
    input  wire logic [11:0]                                    base,
    // Levels to the block
    output logic      [adcrc_pkg::CHANNELS*adcrc_pkg::RESULT_W-1:0] analog_input_level
);
    import adcrc_pkg::*;
    // Only the routed channel shows its true level; each other channel shows the inverse of its own,
    // so a wrong routing choice cannot match by luck.
    always_comb begin
        for (int n = 0; n < CHANNELS; n++) begin
            if (4'(n) == channel_select) begin
                analog_input_level[n*RESULT_W +: RESULT_W] = base + 12'(n * 241);
            end else begin
                analog_input_level[n*RESULT_W +: RESULT_W] = ~(base + 12'(n * 241));
            end
        end
    end
endmodule

// ### verification/adcrc_top_tb.sv
`timescale 1ns/1ps
module adcrc_top_tb;
    import adcrc_pkg::*;
    localparam int S12 = 4;
    localparam int S8  = 3;
    localparam int SC  = 2;
    logic                         clk_sys;
    logic                         resetn;
    logic                         psel;
    logic                         penable;
    logic                         pwrite;
    logic [ADDR_W-1:0]            paddr;
    logic [31:0]                  pwdata;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic [CHANNELS*RESULT_W-1:0] lvls;
    logic [3:0]                   channel_select;
    logic                         conv_active;
    logic                         offset_comp_enable;
    logic                         done_irq;
    logic [11:0]                  base;
    logic [31:0]                  rdat;
    logic                         rerr;
    int                           fails;
    int                           n_tests;

    adcrc_top #(.STEPS12(S12), .STEPS8(S8), .STEPSCMP(SC)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .analog_input_level(lvls),
        .channel_select(channel_select), .conv_active(conv_active),
        .offset_comp_enable(offset_comp_enable), .done_irq(done_irq));

    adcrc_fe_model u_fe (.channel_select(channel_select), .base(base),
        .analog_input_level(lvls));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [11:0] lvl(input int ch);
        return base + 12'(ch * 241);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input string msg);
        apb(1'b0, idx, 8'h00);
        chk(rdat, {24'h000000, exp}, msg);
    endtask

    // Counts the cycles that the converter stays busy after the start write.
    task automatic conv(input logic [7:0] c, input int t);
        int n;
        n = 0;
        apb(1'b1, IDX_CTRL, c);
        @(posedge clk_sys);
        while (conv_active === 1'b1 && n < 2000) begin
            n++;
            @(posedge clk_sys);
        end
        chk(n, t, "conversion time");
        rchk(IDX_CTRL, (c & 8'hfb) | 8'h02, "done set, start clear");
        chk(done_irq, c[0], "irq request");
        apb(1'b1, IDX_CTRL, c & 8'hf9);
        rchk(IDX_CTRL, c & 8'hf9, "done cleared");
        chk(done_irq, 1'b0, "irq request dropped");
    endtask

    task automatic t_regs;
        rchk(IDX_CTRL, 8'h00, "ctrl reset");
        rchk(IDX_MODE, 8'h00, "mode reset");
        rchk(IDX_LOW, 8'h00, "low reset");
        rchk(IDX_HIGH, 8'h00, "high reset");
        apb(1'b1, 16'h7f24, 8'hff);
        chk(rerr, 1'b1, "unmapped write refused");
        rchk(16'h7f24, 8'h00, "unmapped read zero");
        chk(rerr, 1'b1, "unmapped read refused");
        apb(1'b1, IDX_HIGH, 8'ha5);
        rchk(IDX_HIGH, 8'ha5, "high storage");
        apb(1'b1, IDX_LOW, 8'hf1);
        rchk(IDX_LOW, 8'hf1, "low storage");
        apb(1'b1, IDX_LOW, 8'h00);
    endtask

    task automatic t_conv12;
        apb(1'b1, IDX_MODE, 8'h00);
        conv(8'h15, 2 * (S12 + 2));
        chk(channel_select, 4'h1, "channel one routed");
        rchk(IDX_HIGH, 8'(lvl(1) >> 4), "high upper bits");
        rchk(IDX_LOW, 8'(lvl(1) << 4), "low nibble");
        conv(8'h14, S12 + 2);
        // The clearing write below lands on the very edge at which the run completes.
        apb(1'b1, IDX_CTRL, 8'h14);
        repeat (S12 - 1) @(posedge clk_sys);
        apb(1'b1, IDX_CTRL, 8'h10);
        rchk(IDX_CTRL, 8'h12, "completion beats clearing write");
        apb(1'b1, IDX_CTRL, 8'h10);
        rchk(IDX_CTRL, 8'h10, "done cleared after race");
    endtask

    task automatic t_div;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, IDX_MODE, 8'h40 | 8'(c % 4));
            apb(1'b1, IDX_LOW, 8'ha0 | 8'(c / 4));
            conv(8'(((c + 3) << 4) | 4), S8 * (1 << c) + 2);
            rchk(IDX_HIGH, 8'(lvl(c + 3) >> 4), "8-bit result");
            rchk(IDX_LOW, 8'ha0 | 8'(c / 4), "low kept");
        end
        apb(1'b1, IDX_MODE, 8'h00);
        apb(1'b1, IDX_LOW, 8'h00);
        conv(8'h24, 2 * (S12 + 2));
    endtask

    task automatic t_cmp;
        apb(1'b1, IDX_MODE, 8'h05);
        apb(1'b1, IDX_LOW, 8'h51);
        apb(1'b1, IDX_HIGH, 8'(lvl(6) >> 4) - 8'h01);
        conv(8'h6c, SC * 32 + 2);
        chk(offset_comp_enable, 1'b1, "offset comp on");
        rchk(IDX_LOW, 8'hd1, "reference below input");
        apb(1'b1, IDX_HIGH, 8'(lvl(6) >> 4) + 8'h01);
        conv(8'h6c, SC * 32 + 2);
        rchk(IDX_LOW, 8'h51, "reference above input");
        rchk(IDX_HIGH, 8'(lvl(6) >> 4) + 8'h01, "reference kept");
    endtask

    task automatic t_abort;
        apb(1'b1, IDX_MODE, 8'h00);
        apb(1'b1, IDX_CTRL, 8'h24);
        apb(1'b1, IDX_CTRL, 8'h20);
        @(posedge clk_sys);
        chk(conv_active, 1'b0, "abort stops");
        // The divider still selects 16 here, so wait out a full doubled run.
        repeat (2 * (16 * S12 + 2)) @(posedge clk_sys);
        rchk(IDX_CTRL, 8'h20, "no done after abort");
        rchk(IDX_HIGH, 8'(lvl(6) >> 4) + 8'h01, "abort keeps result");
    endtask

    task automatic t_rst;
        apb(1'b1, IDX_CTRL, 8'h14);
        @(posedge clk_sys);
        resetn <= 1'b0;
        @(posedge clk_sys);
        chk(conv_active, 1'b0, "reset stops converter");
        resetn <= 1'b1;
        rchk(IDX_CTRL, 8'h00, "reset clears start");
        conv(8'h14, 2 * (S12 + 2));
        chk(conv_active, 1'b0, "start clear before going quiet");
    endtask

    task automatic stop_test;
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = 32'h00000000;
        base    = 12'h3a7;
        fails   = 0;
        n_tests = 0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs();
        t_conv12();
        t_div();
        t_cmp();
        t_abort();
        t_rst();
        stop_test();
    end

    // The full sequence needs under two thousand cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
